// ==== dv/counter_clock_mode_select_chk.sv ====
// Purpose: Port-level checker for the counter mode and source block
// Assumes: Register writes complete at the edge where waitrequest is low
// Notes: Mirrors the mode bytes from bus writes so gating can be judged
`timescale 1ns/1ps
module counter_clock_mode_select_chk (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [cnt_cfg_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic idle_mode_i,
  input wire logic [cnt_cfg_pkg::NUM_MOD-1:0] count_tick_o,
  input wire logic watchdog_reset_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [7:0] base_q;
  logic [7:0] ctl_q;
  logic [7:0] run_q;
  logic [7:0] s01_q;
  wire logic acc = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  wire logic [7:0] ix = avs_address_i[cnt_cfg_pkg::ADDR_W-1:2];
  ////////////////////////////////////////
  // Shadow copies let the gating checks follow software setup
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      base_q <= 8'h00;
      ctl_q <= 8'h00;
      run_q <= 8'h00;
      s01_q <= 8'h00;
    end else if (acc) begin
      if (ix == cnt_cfg_pkg::IDX_MODE_BASE) base_q <= avs_writedata_i[7:0];
      if (ix == cnt_cfg_pkg::IDX_CTRL) ctl_q <= avs_writedata_i[7:0];
      if (ix == cnt_cfg_pkg::IDX_RUN) run_q <= avs_writedata_i[7:0];
      if (ix == cnt_cfg_pkg::IDX_SEL_01) s01_q <= avs_writedata_i[7:0];
    end
  end
  ////////////////////////////////////////
  chk_wait_first: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("waitrequest low in first access cycle");
  chk_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("more than one wait cycle");
  chk_rdata_upper: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  chk_reset_quiet: assert property ($fell(sys_rst_i) |-> count_tick_o == 5'h00 && !irq_o && !watchdog_reset_o)
    else $error("outputs active after reset");
  chk_idle_common: assert property (
    !run_q[5] && base_q[7] && idle_mode_i |=> count_tick_o == 5'h00) else $error("array counted in idle");
  chk_legacy_off: assert property (
    !run_q[5] && !ctl_q[6] |=> count_tick_o == 5'h00) else $error("legacy count while stopped");
  chk_idle_mod0: assert property (
    run_q[5] && s01_q[3] && idle_mode_i |=> !count_tick_o[0]) else $error("module 0 counted in idle");
  chk_ext_run_mod0: assert property (
    run_q[5] && !run_q[0] |=> !count_tick_o[0]) else $error("module 0 counted with run bit clear");
  chk_irq_gate: assert property (
    (!run_q[5] && !base_q[0]) [*2] |-> !irq_o) else $error("irq while overflow interrupt disabled");
  chk_wdog_gate: assert property (
    !base_q[6] && !$past(base_q[6]) |-> !watchdog_reset_o) else $error("watchdog while disabled");
  chk_wdog_pulse: assert property (watchdog_reset_o |=> !watchdog_reset_o)
    else $error("watchdog pulse too long");
  cp_irq: cover property ($rose(irq_o));
  cp_wdog: cover property (watchdog_reset_o);
  cp_idle: cover property (idle_mode_i && run_q[5] && s01_q[3]);
endmodule
bind counter_clock_mode_select counter_clock_mode_select_chk chk_i (.clk_i, .sys_rst_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
  .idle_mode_i, .count_tick_o, .watchdog_reset_o, .irq_o);

// ==== dv/tb.sv ====
// Purpose: Self-checking bench for the counter mode and source block
// Assumes: Counter width shrunk to 4 so roll-over comes quickly
// Notes: Periodic source pulses give exact tick counts in any 48-cycle window
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [cnt_cfg_pkg::ADDR_W-1:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic idle_mode_i = 1'b0;
  logic timer0_ovf_i = 1'b0;
  logic timer1_ovf_i = 1'b0;
  logic baud_ovf_i = 1'b0;
  logic ext_count_input_i = 1'b0;
  logic [cnt_cfg_pkg::NUM_MOD-1:0] count_tick_o;
  logic watchdog_reset_o;
  logic irq_o;
  logic [7:0] q;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  int wd_seen = 0;
  int wb;
  int a;
  int b;
  int cnt [5];
  int ex [8] = '{4, 12, 8, 6, 24, 12, 0, 16};
  int seq [7] = '{0, 1, 2, 3, 4, 5, 7};
  logic [7:0] ix4 [4] = '{8'hD9, 8'hDF, 8'hEF, 8'hFF};
  logic [7:0] wv [4] = '{8'hC7, 8'hA5, 8'h5A, 8'h0F};

  counter_clock_mode_select #(.CNT_W(4)) counter_clock_mode_select_i (.clk_i, .sys_rst_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .idle_mode_i, .timer0_ovf_i, .timer1_ovf_i, .baud_ovf_i, .ext_count_input_i, .count_tick_o,
    .watchdog_reset_o, .irq_o);

  always #2.5 clk_i = ~clk_i;
  ////////////////////////////////////////
  // Sources stay slower than the clock; the pin toggles at one eighth of it
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    timer0_ovf_i <= (cyc % 6 == 0);
    timer1_ovf_i <= (cyc % 4 == 0);
    baud_ovf_i <= (cyc % 3 == 0);
    ext_count_input_i <= cyc[2];
    if (watchdog_reset_o === 1'b1) wd_seen <= wd_seen + 1;
  end
  ////////////////////////////////////////
  task automatic final_report();
    $display("Checks %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input bit w, input logic [7:0] ix, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    avs_address_i <= {ix, 2'b00};
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= {24'h000000, d};
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    q = avs_readdata_o[7:0];
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (n == 20) begin
      failures++;
      $display("Error %0t: bus timeout", $time);
      final_report();
    end
  endtask

  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    bus(1'b1, ix, d);
  endtask

  task automatic rd(input logic [7:0] ix, input logic [7:0] e);
    bus(1'b0, ix, 8'h00);
    cmp8(q, e);
  endtask

  task automatic meas();
    cnt = '{default: 0};
    repeat (16) @(posedge clk_i);
    repeat (48) begin
      @(negedge clk_i);
      for (int i = 0; i < 5; i++) if (count_tick_o[i] === 1'b1) cnt[i]++;
    end
    // Hand back on a rising edge so the next stimulus starts there
    @(posedge clk_i);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 4; i++) rd(ix4[i], 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(ix4[i], wv[i]);
      rd(ix4[i], wv[i]);
    end
    wr(8'h10, 8'h55);
    rd(8'h10, 8'h00);
    // A write without byte lane 0 must leave the register alone
    avs_byteenable_i <= 4'h0;
    wr(cnt_cfg_pkg::IDX_SEL_01, 8'h11);
    avs_byteenable_i <= 4'hF;
    rd(cnt_cfg_pkg::IDX_SEL_01, 8'hA5);
    wr(cnt_cfg_pkg::IDX_CTRL, 8'h40);
    wr(cnt_cfg_pkg::IDX_RUN, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(cnt_cfg_pkg::IDX_MODE_BASE, 8'(c * 2));
      meas();
      for (int m = 0; m < 5; m++) cmp8(8'(cnt[m]), 8'(ex[c]));
    end
    wr(cnt_cfg_pkg::IDX_RUN, 8'h3F);
    for (int k = 0; k < 7; k++) begin
      a = seq[k];
      b = seq[(k + 3) % 7];
      wr(cnt_cfg_pkg::IDX_SEL_01, {1'b0, 3'(b), 1'b0, 3'(a)});
      wr(cnt_cfg_pkg::IDX_SEL_23, {1'b0, 3'(b), 1'b0, 3'(a)});
      wr(cnt_cfg_pkg::IDX_SEL_4, {5'h00, 3'(a)});
      meas();
      for (int m = 0; m < 5; m++) cmp8(8'(cnt[m]), 8'(ex[(m % 2) ? b : a]));
    end
    wr(cnt_cfg_pkg::IDX_SEL_01, 8'h4C);
    idle_mode_i <= 1'b1;
    meas();
    cmp8(8'(cnt[0]), 8'h00);
    cmp8(8'(cnt[1]), 8'h18);
    idle_mode_i <= 1'b0;
    wr(cnt_cfg_pkg::IDX_RUN, 8'h3E);
    meas();
    cmp8(8'(cnt[0]), 8'h00);
    wr(cnt_cfg_pkg::IDX_RUN, 8'h00);
    wr(cnt_cfg_pkg::IDX_MODE_BASE, 8'h82);
    idle_mode_i <= 1'b1;
    meas();
    cmp8(8'(cnt[0]), 8'h00);
    wr(cnt_cfg_pkg::IDX_MODE_BASE, 8'h02);
    meas();
    cmp8(8'(cnt[0]), 8'h0C);
    idle_mode_i <= 1'b0;
    wr(cnt_cfg_pkg::IDX_CTRL, 8'h00);
    meas();
    cmp8(8'(cnt[0]), 8'h00);
    wr(cnt_cfg_pkg::IDX_RUN, 8'h3F);
    meas();
    cmp8(8'(cnt[0]), 8'h18);
    // Interrupt: raise while masked, unmask, then clear one flag
    wr(cnt_cfg_pkg::IDX_RUN, 8'h00);
    wr(cnt_cfg_pkg::IDX_FLAGS, 8'h1F);
    rd(cnt_cfg_pkg::IDX_FLAGS, 8'h00);
    wb = wd_seen;
    wr(cnt_cfg_pkg::IDX_MODE_BASE, 8'h42);
    wr(cnt_cfg_pkg::IDX_CTRL, 8'h40);
    repeat (80) @(posedge clk_i);
    wr(cnt_cfg_pkg::IDX_CTRL, 8'h00);
    rd(cnt_cfg_pkg::IDX_FLAGS, 8'h1F);
    cmp8({7'h00, irq_o}, 8'h00);
    cmp8(8'(wd_seen > wb), 8'h01);
    wr(cnt_cfg_pkg::IDX_MODE_BASE, 8'h43);
    repeat (2) @(negedge clk_i);
    cmp8({7'h00, irq_o}, 8'h01);
    wr(cnt_cfg_pkg::IDX_FLAGS, 8'h01);
    repeat (2) @(negedge clk_i);
    cmp8({7'h00, irq_o}, 8'h00);
    rd(cnt_cfg_pkg::IDX_FLAGS, 8'h1E);
    // Extended mode: the per-counter enable mask gates the flags instead
    wr(cnt_cfg_pkg::IDX_RUN, 8'h20);
    wr(cnt_cfg_pkg::IDX_IRQ_EN, 8'h01);
    repeat (2) @(negedge clk_i);
    cmp8({7'h00, irq_o}, 8'h00);
    wr(cnt_cfg_pkg::IDX_IRQ_EN, 8'h10);
    repeat (2) @(negedge clk_i);
    cmp8({7'h00, irq_o}, 8'h01);
    rd(cnt_cfg_pkg::IDX_IRQ_EN, 8'h10);
    final_report();
  end
endmodule

// ==== src/cnt_cfg_pkg.sv ====
// Purpose: Shared constants for the counter array source and mode logic
// Assumes: Byte-wide registers, one per 32-bit Avalon word
// Notes: Register index times four gives the byte address
// Functional notes
// - Common idle-stop bit halts array in idle
// - Base bit 6 enables module 4 watchdog
// - Common source: 00 /12, 01 /4, 10 timer0
// - Base bit 0 gates overflow flag interrupt
// - Module source 000-011: /12, /4, timer0, pin
// - Module source 100 /2, 101 timer1, 111 baud
// - Each module has its own idle-stop bit
// - Pair registers: odd bits 7:4, even 3:0
// - Reserved mode bits read undefined, never written
// - Mode bit picks legacy or extended run control
// - Roll-over sets flag, software clears, enable gates
package cnt_cfg_pkg;
  localparam int unsigned NUM_MOD = 5;
  localparam int unsigned ADDR_W = 10;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_MODE_BASE = 8'hD9;
  localparam logic [7:0] IDX_SEL_01 = 8'hDF;
  localparam logic [7:0] IDX_SEL_23 = 8'hEF;
  localparam logic [7:0] IDX_SEL_4 = 8'hFF;
  localparam logic [7:0] IDX_CTRL = 8'hD8;
  localparam logic [7:0] IDX_FLAGS = 8'hE1;
  localparam logic [7:0] IDX_RUN = 8'hE2;
  localparam logic [7:0] IDX_IRQ_EN = 8'hE3;
  // Base mode register fields
  localparam int unsigned BIT_COMMON_IDLE = 7;
  localparam int unsigned BIT_WDOG = 6;
  localparam int unsigned BIT_SRC_HI = 2;
  localparam int unsigned BIT_SRC_LO = 1;
  localparam int unsigned BIT_OVF_IRQ_EN = 0;
  localparam logic [7:0] MODE_BASE_WMASK = 8'hC7;
  // Pair register fields
  localparam int unsigned BIT_IDLE_ODD = 7;
  localparam int unsigned BIT_IDLE_EVEN = 3;
  localparam int unsigned SRC_ODD_LSB = 4;
  localparam int unsigned SRC_EVEN_LSB = 0;
  localparam logic [7:0] SEL_4_WMASK = 8'h0F;
  // Control and run fields
  localparam int unsigned BIT_LEGACY_RUN = 6;
  localparam int unsigned BIT_EXT_MODE = 5;
  localparam logic [7:0] RUN_WMASK = 8'h3F;
  localparam logic [7:0] CTRL_WMASK = 8'h40;
  localparam logic [7:0] FLAG_MASK = 8'h1F;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Prescaler
  localparam int unsigned DIV_SLOW = 12;
  localparam int unsigned DIV_MID = 4;
  localparam int unsigned DIV_FAST = 2;
  typedef enum logic [2:0] {
    SRC_DIV12 = 3'h0,
    SRC_DIV4 = 3'h1,
    SRC_TMR0 = 3'h2,
    SRC_EXT = 3'h3,
    SRC_DIV2 = 3'h4,
    SRC_TMR1 = 3'h5,
    SRC_RSVD = 3'h6,
    SRC_BAUD = 3'h7
  } src_sel_t;
endpackage

// ==== src/count_tick_gen.sv ====
// Purpose: Oscillator prescaler ticks and external pin edge pulses
// Assumes: clk_i is the oscillator clock; ext pin synchronous to it
// Notes: One modulo-12 counter serves all three divided rates
`timescale 1ns/1ps
module count_tick_gen (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ext_count_input_i,
  output logic tick_div12_o,
  output logic tick_div4_o,
  output logic tick_div2_o,
  output logic tick_ext_o
);
  localparam logic [3:0] LAST = 4'(cnt_cfg_pkg::DIV_SLOW - 1);
  localparam logic [3:0] MID_M = 4'(cnt_cfg_pkg::DIV_MID - 1);
  localparam logic [3:0] FAST_M = 4'(cnt_cfg_pkg::DIV_FAST - 1);

  logic [3:0] div_reg;
  logic ext_prev_reg;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      div_reg <= 4'h0;
    end else if (div_reg == LAST) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  // Edge detect on the pin; a faster source than Fosc/2 would alias
  // Tracks the pin through reset too, so a pin already high at release is no false edge
  always_ff @(posedge clk_i) begin
    ext_prev_reg <= ext_count_input_i;
  end

  // Twelve is a multiple of four and two, so the masks give exact rates
  assign tick_div12_o = (div_reg == LAST);
  assign tick_div4_o = ((div_reg & MID_M) == MID_M);
  assign tick_div2_o = ((div_reg & FAST_M) == FAST_M);
  assign tick_ext_o = ext_count_input_i & ~ext_prev_reg;
endmodule

// ==== src/counter_clock_mode_select.sv ====
// Purpose: Counter array mode, count-source and idle control with Avalon registers
// Assumes: Overflow and pin inputs synchronous to clk_i, one-cycle pulses
// Notes: Legacy mode uses the common fields, extended mode the per-module ones
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
module counter_clock_mode_select #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [cnt_cfg_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic idle_mode_i,
  input wire logic timer0_ovf_i,
  input wire logic timer1_ovf_i,
  input wire logic baud_ovf_i,
  input wire logic ext_count_input_i,
  output logic [cnt_cfg_pkg::NUM_MOD-1:0] count_tick_o,
  output logic watchdog_reset_o,
  output logic irq_o
);
  localparam int unsigned NM = cnt_cfg_pkg::NUM_MOD;

  ////////////////////////////////////////////////////////////////////////////
  // Signals

  logic [7:0] mode_base_reg;
  logic [7:0] sel_01_reg;
  logic [7:0] sel_23_reg;
  logic [7:0] sel_4_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] run_reg;
  logic [NM-1:0] flag_reg;
  logic [NM-1:0] flag_next;
  logic [NM-1:0] irq_en_reg;
  logic [CNT_W-1:0] count_reg [NM];
  logic [NM-1:0] tick;
  logic [NM-1:0] ovf;
  logic [NM-1:0] running;
  logic [NM-1:0] idle_stop;
  logic [2:0] src_code [NM];
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic req;
  logic wr_en;
  logic [7:0] widx;
  logic [7:0] wbyte;
  logic t_div12;
  logic t_div4;
  logic t_div2;
  logic t_ext;
  logic ext_mode;
  logic [1:0] common_src;
  logic [2:0] ext_src [NM];
  logic [NM-1:0] ext_idle;
  logic [NM-1:0] count_en;
  logic [7:0] rbyte;
  logic irq_next;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Word-aligned decode of the byte address into a register index
  function automatic logic [7:0] addr_index(input logic [cnt_cfg_pkg::ADDR_W-1:0] a);
    addr_index = a[cnt_cfg_pkg::ADDR_W-1:2];
  endfunction

  // One register's write strobe; keeps the decode in one place
  function automatic logic reg_write_hit(input logic en, input logic [7:0] idx,
                                         input logic [7:0] target);
    reg_write_hit = en & (idx == target);
  endfunction

  // Source field of a pair register; odd modules sit in the high nibble
  function automatic logic [2:0] pair_src(input logic [7:0] r, input logic odd);
    if (odd) begin
      pair_src = r[cnt_cfg_pkg::SRC_ODD_LSB +: 3];
    end else begin
      pair_src = r[cnt_cfg_pkg::SRC_EVEN_LSB +: 3];
    end
  endfunction

  // Idle-stop bit of a pair register
  function automatic logic pair_idle(input logic [7:0] r, input logic odd);
    if (odd) begin
      pair_idle = r[cnt_cfg_pkg::BIT_IDLE_ODD];
    end else begin
      pair_idle = r[cnt_cfg_pkg::BIT_IDLE_EVEN];
    end
  endfunction

  // Module source code to tick; reserved code counts nothing
  function automatic logic pick_tick(input logic [2:0] code, input logic d12,
                                     input logic d4, input logic d2, input logic t0,
                                     input logic t1, input logic bd, input logic ex);
    case (code)
      cnt_cfg_pkg::SRC_DIV12: pick_tick = d12;
      cnt_cfg_pkg::SRC_DIV4: pick_tick = d4;
      cnt_cfg_pkg::SRC_TMR0: pick_tick = t0;
      cnt_cfg_pkg::SRC_EXT: pick_tick = ex;
      cnt_cfg_pkg::SRC_DIV2: pick_tick = d2;
      cnt_cfg_pkg::SRC_TMR1: pick_tick = t1;
      cnt_cfg_pkg::SRC_BAUD: pick_tick = bd;
      default: pick_tick = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Tick sources

  count_tick_gen u_tick (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ext_count_input_i(ext_count_input_i),
    .tick_div12_o(t_div12),
    .tick_div4_o(t_div4),
    .tick_div2_o(t_div2),
    .tick_ext_o(t_ext)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then answer

  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_reg;
  assign widx = addr_index(avs_address_i);
  assign wbyte = avs_writedata_i[7:0];
  // Write takes effect on the edge where waitrequest is seen low
  assign wr_en = avs_write_i & ack_reg & avs_byteenable_i[0];
  assign avs_readdata_o = rdata_reg;

  // Ack clears itself, so a request held on gets a fresh wait cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // Reserved bits and unmapped indices read as zero, the chosen value for undefined
  always_comb begin
    case (widx)
      cnt_cfg_pkg::IDX_MODE_BASE: rbyte = mode_base_reg;
      cnt_cfg_pkg::IDX_SEL_01: rbyte = sel_01_reg;
      cnt_cfg_pkg::IDX_SEL_23: rbyte = sel_23_reg;
      cnt_cfg_pkg::IDX_SEL_4: rbyte = sel_4_reg;
      cnt_cfg_pkg::IDX_CTRL: rbyte = ctrl_reg;
      cnt_cfg_pkg::IDX_RUN: rbyte = run_reg;
      cnt_cfg_pkg::IDX_FLAGS: rbyte = 8'(flag_reg);
      cnt_cfg_pkg::IDX_IRQ_EN: rbyte = 8'(irq_en_reg);
      default: rbyte = cnt_cfg_pkg::RESET_BYTE;
    endcase
  end

  // Loaded in the wait cycle so the byte stands when waitrequest drops
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read_i & ~ack_reg) begin
      rdata_reg <= 32'(rbyte);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers; reserved bits are masked off on write

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mode_base_reg <= cnt_cfg_pkg::RESET_BYTE;
    end else if (reg_write_hit(wr_en, widx, cnt_cfg_pkg::IDX_MODE_BASE)) begin
      mode_base_reg <= wbyte & cnt_cfg_pkg::MODE_BASE_WMASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sel_01_reg <= cnt_cfg_pkg::RESET_BYTE;
    end else if (reg_write_hit(wr_en, widx, cnt_cfg_pkg::IDX_SEL_01)) begin
      sel_01_reg <= wbyte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sel_23_reg <= cnt_cfg_pkg::RESET_BYTE;
    end else if (reg_write_hit(wr_en, widx, cnt_cfg_pkg::IDX_SEL_23)) begin
      sel_23_reg <= wbyte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sel_4_reg <= cnt_cfg_pkg::RESET_BYTE;
    end else if (reg_write_hit(wr_en, widx, cnt_cfg_pkg::IDX_SEL_4)) begin
      sel_4_reg <= wbyte & cnt_cfg_pkg::SEL_4_WMASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= cnt_cfg_pkg::RESET_BYTE;
    end else if (reg_write_hit(wr_en, widx, cnt_cfg_pkg::IDX_CTRL)) begin
      ctrl_reg <= wbyte & cnt_cfg_pkg::CTRL_WMASK;
    end
  end

  // Reset leaves the array in legacy mode
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      run_reg <= cnt_cfg_pkg::RESET_BYTE;
    end else if (reg_write_hit(wr_en, widx, cnt_cfg_pkg::IDX_RUN)) begin
      run_reg <= wbyte & cnt_cfg_pkg::RUN_WMASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_en_reg <= '0;
    end else if (reg_write_hit(wr_en, widx, cnt_cfg_pkg::IDX_IRQ_EN)) begin
      irq_en_reg <= wbyte[NM-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-module source and idle fields

  assign ext_mode = run_reg[cnt_cfg_pkg::BIT_EXT_MODE];
  assign common_src = {mode_base_reg[cnt_cfg_pkg::BIT_SRC_HI], mode_base_reg[cnt_cfg_pkg::BIT_SRC_LO]};

  // Even module in the low nibble, odd in the high nibble
  always_comb begin
    ext_src[0] = pair_src(sel_01_reg, 1'b0);
    ext_src[1] = pair_src(sel_01_reg, 1'b1);
    ext_src[2] = pair_src(sel_23_reg, 1'b0);
    ext_src[3] = pair_src(sel_23_reg, 1'b1);
    ext_src[4] = pair_src(sel_4_reg, 1'b0);
    ext_idle[0] = pair_idle(sel_01_reg, 1'b0);
    ext_idle[1] = pair_idle(sel_01_reg, 1'b1);
    ext_idle[2] = pair_idle(sel_23_reg, 1'b0);
    ext_idle[3] = pair_idle(sel_23_reg, 1'b1);
    ext_idle[4] = pair_idle(sel_4_reg, 1'b0);
  end

  // Legacy: codes 00..11 of the common field map onto the low four module codes
  always_comb begin
    for (int m = 0; m < NM; m++) begin
      if (ext_mode) begin
        src_code[m] = ext_src[m];
        idle_stop[m] = ext_idle[m];
      end else begin
        src_code[m] = {1'b0, common_src};
        idle_stop[m] = mode_base_reg[cnt_cfg_pkg::BIT_COMMON_IDLE];
      end
    end
  end

  always_comb begin
    for (int m = 0; m < NM; m++) begin
      tick[m] = pick_tick(src_code[m], t_div12, t_div4, t_div2, timer0_ovf_i,
                          timer1_ovf_i, baud_ovf_i, t_ext);
      // Extended mode uses per-counter run bits, legacy the single one
      running[m] = (ext_mode ? run_reg[m] : ctrl_reg[cnt_cfg_pkg::BIT_LEGACY_RUN])
                   & ~(idle_mode_i & idle_stop[m]);
      ovf[m] = running[m] & tick[m] & (&count_reg[m]);
    end
  end

  // One shared enable keeps the counters and the tick output in step
  assign count_en = running & tick;

  ////////////////////////////////////////////////////////////////////////////
  // Counters

  // Counters wrap silently; a roll-over shows only through the flags and, for module 4, the watchdog
  always_ff @(posedge clk_i) begin
    for (int m = 0; m < NM; m++) begin
      if (sys_rst_i) begin
        count_reg[m] <= '0;
      end else if (count_en[m]) begin
        count_reg[m] <= count_reg[m] + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      count_tick_o <= '0;
    end else begin
      count_tick_o <= count_en;
    end
  end

  // Watchdog on module 4 fires on its roll-over while enabled
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      watchdog_reset_o <= 1'b0;
    end else begin
      watchdog_reset_o <= mode_base_reg[cnt_cfg_pkg::BIT_WDOG] & ovf[NM-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overflow flags and interrupt

  // Write one to clear; a roll-over in the same cycle wins
  always_comb begin
    flag_next = flag_reg;
    if (reg_write_hit(wr_en, widx, cnt_cfg_pkg::IDX_FLAGS)) begin
      flag_next = flag_reg & ~wbyte[NM-1:0];
    end
    flag_next = flag_next | ovf;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // Legacy: base bit 0 gates the module 0 flag; extended: enable mask
  always_comb begin
    if (ext_mode) begin
      irq_next = |(flag_next & irq_en_reg);
    end else begin
      irq_next = flag_next[0] & mode_base_reg[cnt_cfg_pkg::BIT_OVF_IRQ_EN];
    end
  end

  // Registered so the request line never glitches while flags settle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_next;
    end
  end
endmodule
